/* File: core/arith_pkg.sv */
// shared constants and types for the signed arithmetic unit
package arith_pkg;
    // ***********************************
    // widths
    // ***********************************
    localparam int W_WIDE = 32;
    localparam int W_NARROW = 16;
    localparam int W_PROD_WIDE = 64;
    // ***********************************
    // sequential unit indices
    // ***********************************
    localparam int N_UNITS = 4;
    localparam int U_MUL_W = 0;
    localparam int U_MUL_N = 1;
    localparam int U_DIV_W = 2;
    localparam int U_DIV_N = 3;
    // ***********************************
    // timing counts and limits
    // ***********************************
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic signed [32:0] NARROW_MAX = 33'sh0_0000_7fff;
    localparam logic signed [32:0] NARROW_MIN = -33'sh0_0000_8000;
    // ***********************************
    // divider core state
    // ***********************************
    typedef enum logic {
        core_idle,
        core_run
    } core_state_e;
endpackage : arith_pkg

/* File: core/div_core.sv */
// iterative signed divider core, truncating quotient
`timescale 1ns/1ps
`default_nettype none
module div_core (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic start,
    input wire logic abort,
    // operands
    input wire logic [31:0] dividend,
    input wire logic [31:0] divisor,
    // results
    output logic done,
    output logic [32:0] quotient,
    output logic [31:0] remainder,
    output logic div_zero
);
    // ***********************************
    // state
    // ***********************************
    arith_pkg::core_state_e state_q;
    logic [5:0] cnt_q;
    logic [31:0] rem_q;
    logic [31:0] quo_q;
    logic [31:0] den_q;
    logic neg_q_q;
    logic neg_r_q;
    logic [32:0] shifted;
    logic [33:0] trial;
    logic ge;
    logic [31:0] rem_n;
    logic [31:0] quo_n;

    // one restoring step on magnitudes
    always_comb begin
        shifted = {rem_q, quo_q[31]};
        trial = {1'b0, shifted} - {2'b00, den_q};
        ge = ~trial[33];
        rem_n = ge ? trial[31:0] : shifted[31:0];
        quo_n = {quo_q[30:0], ge};
    end

    // sequencing: load, 32 steps, then a one-cycle done
    always_ff @(posedge clock) begin
        if (srst || abort) begin
            state_q <= arith_pkg::core_idle;
            cnt_q <= 6'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                arith_pkg::core_idle: begin
                    if (start) begin
                        state_q <= arith_pkg::core_run;
                        cnt_q <= arith_pkg::DIV_STEPS;
                    end
                end
                arith_pkg::core_run: begin
                    cnt_q <= cnt_q - 6'h01;
                    if (cnt_q == 6'h01) begin
                        state_q <= arith_pkg::core_idle;
                        done <= 1'b1;
                    end
                end
                default: state_q <= arith_pkg::core_idle;
            endcase
        end
    end

    // datapath; magnitudes so -2^31 is handled as 2^31 unsigned
    always_ff @(posedge clock) begin
        if (srst) begin
            rem_q <= 32'h0000_0000;
            quo_q <= 32'h0000_0000;
            den_q <= 32'h0000_0000;
            neg_q_q <= 1'b0;
            neg_r_q <= 1'b0;
            quotient <= 33'h0_0000_0000;
            remainder <= 32'h0000_0000;
            div_zero <= 1'b0;
        end else if (state_q == arith_pkg::core_idle && start) begin
            rem_q <= 32'h0000_0000;
            quo_q <= dividend[31] ? 32'(-dividend) : dividend;
            den_q <= divisor[31] ? 32'(-divisor) : divisor;
            neg_q_q <= dividend[31] ^ divisor[31];
            neg_r_q <= dividend[31];
            div_zero <= (divisor == 32'h0000_0000);
        end else if (state_q == arith_pkg::core_run) begin
            rem_q <= rem_n;
            quo_q <= quo_n;
            if (cnt_q == 6'h01) begin
                // truncation toward zero, remainder follows dividend sign
                quotient <= neg_q_q ? 33'(-{1'b0, quo_n}) : {1'b0, quo_n};
                remainder <= neg_r_q ? 32'(-rem_n) : rem_n;
            end
        end
    end
endmodule : div_core
`default_nettype wire

/* File: core/signed_integer_arith_unit.sv */
// signed add, subtract, multiply and divide blocks
`timescale 1ns/1ps
`default_nettype none
module signed_integer_arith_unit (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // adders
    input wire logic [31:0] add_a_wide,
    input wire logic [31:0] add_b_wide,
    output logic [31:0] add_sum_wide,
    output logic add_ovf_wide,
    input wire logic [15:0] add_a_narrow,
    input wire logic [15:0] add_b_narrow,
    output logic [15:0] add_sum_narrow,
    output logic add_ovf_narrow,
    // subtractors
    input wire logic [31:0] sub_a_wide,
    input wire logic [31:0] sub_b_wide,
    output logic [31:0] sub_diff_wide,
    output logic sub_ovf_wide,
    input wire logic [15:0] sub_a_narrow,
    input wire logic [15:0] sub_b_narrow,
    output logic [15:0] sub_diff_narrow,
    output logic sub_ovf_narrow,
    // wide multiplier
    input wire logic mul_req_wide,
    input wire logic [31:0] mul_a_wide,
    input wire logic [31:0] mul_b_wide,
    output logic mul_done_wide,
    output logic [31:0] mul_product_wide,
    output logic mul_ovf_wide,
    // narrow multiplier
    input wire logic mul_req_narrow,
    input wire logic [15:0] mul_a_narrow,
    input wire logic [15:0] mul_b_narrow,
    output logic mul_done_narrow,
    output logic [31:0] mul_product_narrow,
    // wide divider
    input wire logic div_req_wide,
    input wire logic [31:0] div_a_wide,
    input wire logic [31:0] div_b_wide,
    output logic div_done_wide,
    output logic [31:0] div_quot_wide,
    output logic [31:0] div_rem_wide,
    output logic div_ovf_wide,
    // narrow divider
    input wire logic div_req_narrow,
    input wire logic [31:0] div_a_narrow,
    input wire logic [15:0] div_b_narrow,
    output logic div_done_narrow,
    output logic [15:0] div_quot_narrow,
    output logic [15:0] div_rem_narrow,
    output logic div_ovf_narrow
);
    // ***********************************
    // add and subtract
    // ***********************************
    logic [32:0] add_w_full;
    logic [16:0] add_n_full;
    logic [32:0] sub_w_full;
    logic [16:0] sub_n_full;

    // one extra sign bit exposes overflow as a mismatch of the top two bits
    always_comb begin
        add_w_full = {add_a_wide[31], add_a_wide} + {add_b_wide[31], add_b_wide};
        add_n_full = {add_a_narrow[15], add_a_narrow} + {add_b_narrow[15], add_b_narrow};
        sub_w_full = {sub_a_wide[31], sub_a_wide} - {sub_b_wide[31], sub_b_wide};
        sub_n_full = {sub_a_narrow[15], sub_a_narrow} - {sub_b_narrow[15], sub_b_narrow};
    end

    // registered so every output leaves from a flop; one cycle of latency
    always_ff @(posedge clock) begin
        if (srst) begin
            add_sum_wide <= 32'h0000_0000;
            add_ovf_wide <= 1'b0;
            add_sum_narrow <= 16'h0000;
            add_ovf_narrow <= 1'b0;
            sub_diff_wide <= 32'h0000_0000;
            sub_ovf_wide <= 1'b0;
            sub_diff_narrow <= 16'h0000;
            sub_ovf_narrow <= 1'b0;
        end else begin
            add_sum_wide <= add_w_full[31:0];
            add_ovf_wide <= add_w_full[32] ^ add_w_full[31];
            add_sum_narrow <= add_n_full[15:0];
            add_ovf_narrow <= add_n_full[16] ^ add_n_full[15];
            sub_diff_wide <= sub_w_full[31:0];
            sub_ovf_wide <= sub_w_full[32] ^ sub_w_full[31];
            sub_diff_narrow <= sub_n_full[15:0];
            sub_ovf_narrow <= sub_n_full[16] ^ sub_n_full[15];
        end
    end

    // ***********************************
    // request and done handshake
    // ***********************************
    logic [arith_pkg::N_UNITS-1:0] req_v;
    logic [arith_pkg::N_UNITS-1:0] fin_v;
    logic [arith_pkg::N_UNITS-1:0] start_v;
    logic [arith_pkg::N_UNITS-1:0] req_prev_q;
    logic [arith_pkg::N_UNITS-1:0] busy_q;
    logic [arith_pkg::N_UNITS-1:0] done_q;
    logic core_done_w;
    logic core_done_n;

    assign req_v = {div_req_narrow, div_req_wide, mul_req_narrow, mul_req_wide};
    // multipliers settle one cycle after start; dividers wait for their core
    assign fin_v = {core_done_n, core_done_w, busy_q[arith_pkg::U_MUL_N],
                    busy_q[arith_pkg::U_MUL_W]};

    for (genvar i = 0; i < arith_pkg::N_UNITS; i++) begin : g_ctl
        assign start_v[i] = req_v[i] & ~req_prev_q[i];

        // a dropped request aborts and clears done in the same edge
        always_ff @(posedge clock) begin
            if (srst) begin
                req_prev_q[i] <= 1'b0;
                busy_q[i] <= 1'b0;
                done_q[i] <= 1'b0;
            end else begin
                req_prev_q[i] <= req_v[i];
                if (!req_v[i]) begin
                    busy_q[i] <= 1'b0;
                    done_q[i] <= 1'b0;
                end else if (start_v[i]) begin
                    busy_q[i] <= 1'b1;
                    done_q[i] <= 1'b0;
                end else if (busy_q[i] && fin_v[i]) begin
                    busy_q[i] <= 1'b0;
                    done_q[i] <= 1'b1;
                end
            end
        end
    end

    assign mul_done_wide = done_q[arith_pkg::U_MUL_W];
    assign mul_done_narrow = done_q[arith_pkg::U_MUL_N];
    assign div_done_wide = done_q[arith_pkg::U_DIV_W];
    assign div_done_narrow = done_q[arith_pkg::U_DIV_N];

    // ***********************************
    // multipliers
    // ***********************************
    logic [63:0] prod_w_q;
    logic [31:0] prod_n_q;

    // operands sampled on the request edge only
    always_ff @(posedge clock) begin
        if (srst) begin
            prod_w_q <= 64'h0000_0000_0000_0000;
            prod_n_q <= 32'h0000_0000;
        end else begin
            if (start_v[arith_pkg::U_MUL_W]) begin
                prod_w_q <= $signed(mul_a_wide) * $signed(mul_b_wide);
            end
            if (start_v[arith_pkg::U_MUL_N]) begin
                prod_n_q <= 32'($signed(mul_a_narrow) * $signed(mul_b_narrow));
            end
        end
    end

    // results update only when an operation completes
    always_ff @(posedge clock) begin
        if (srst) begin
            mul_product_wide <= 32'h0000_0000;
            mul_ovf_wide <= 1'b0;
            mul_product_narrow <= 32'h0000_0000;
        end else begin
            if (busy_q[arith_pkg::U_MUL_W] && mul_req_wide) begin
                mul_product_wide <= prod_w_q[31:0];
                mul_ovf_wide <= (prod_w_q[63:31] != {33{prod_w_q[31]}});
            end
            if (busy_q[arith_pkg::U_MUL_N] && mul_req_narrow) begin
                mul_product_narrow <= prod_n_q;
            end
        end
    end

    // ***********************************
    // dividers
    // ***********************************
    logic [32:0] quo_w;
    logic [31:0] rem_w;
    logic zero_w;
    logic [32:0] quo_n;
    logic [31:0] rem_n;
    logic zero_n;
    logic ovf_w;
    logic ovf_n;

    div_core u_div_wide (
        .clock(clock),
        .srst(srst),
        .start(start_v[arith_pkg::U_DIV_W]),
        .abort(~div_req_wide),
        .dividend(div_a_wide),
        .divisor(div_b_wide),
        .done(core_done_w),
        .quotient(quo_w),
        .remainder(rem_w),
        .div_zero(zero_w)
    );

    div_core u_div_narrow (
        .clock(clock),
        .srst(srst),
        .start(start_v[arith_pkg::U_DIV_N]),
        .abort(~div_req_narrow),
        .dividend(div_a_narrow),
        .divisor({{16{div_b_narrow[15]}}, div_b_narrow}),
        .done(core_done_n),
        .quotient(quo_n),
        .remainder(rem_n),
        .div_zero(zero_n)
    );

    // only -2^31 / -1 escapes the wide range; narrow range is much tighter
    assign ovf_w = zero_w | (quo_w[32] ^ quo_w[31]);
    assign ovf_n = zero_n | ($signed(quo_n) > arith_pkg::NARROW_MAX)
                          | ($signed(quo_n) < arith_pkg::NARROW_MIN);

    always_ff @(posedge clock) begin
        if (srst) begin
            div_quot_wide <= 32'h0000_0000;
            div_rem_wide <= 32'h0000_0000;
            div_ovf_wide <= 1'b0;
            div_quot_narrow <= 16'h0000;
            div_rem_narrow <= 16'h0000;
            div_ovf_narrow <= 1'b0;
        end else begin
            if (core_done_w && busy_q[arith_pkg::U_DIV_W] && div_req_wide) begin
                div_ovf_wide <= ovf_w;
                div_quot_wide <= ovf_w ? 32'h0000_0000 : quo_w[31:0];
                div_rem_wide <= ovf_w ? 32'h0000_0000 : rem_w;
            end
            if (core_done_n && busy_q[arith_pkg::U_DIV_N] && div_req_narrow) begin
                div_ovf_narrow <= ovf_n;
                div_quot_narrow <= ovf_n ? 16'h0000 : quo_n[15:0];
                div_rem_narrow <= ovf_n ? 16'h0000 : rem_n[15:0];
            end
        end
    end

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_mul_edge;
        !mul_req_narrow ##1 mul_req_narrow;
    endsequence
    sequence s_div_zero_start;
        !div_req_narrow ##1 (div_req_narrow && div_b_narrow == 16'h0000);
    endsequence
    chk_add_wide_val: assert property (##1 add_sum_wide ==
        32'($past(add_a_wide) + $past(add_b_wide))) else $error("wide sum wrong");
    chk_add_ovf_flag: assert property (##1 add_ovf_wide ==
        (($past(add_a_wide[31]) == $past(add_b_wide[31]))
        && (add_sum_wide[31] != $past(add_a_wide[31])))) else $error("add overflow wrong");
    chk_sub_ovf_flag: assert property (##1 sub_ovf_narrow ==
        (($past(sub_a_narrow[15]) != $past(sub_b_narrow[15]))
        && (sub_diff_narrow[15] != $past(sub_a_narrow[15])))) else $error("sub overflow wrong");
    chk_mul_done_edge: assert property ($rose(mul_done_wide) |->
        $past(mul_req_wide, 2) && !$past(mul_req_wide, 3)) else $error("done without edge");
    chk_narrow_mul_result: assert property (s_mul_edge ##1 mul_req_narrow |=>
        mul_done_narrow && mul_product_narrow == 32'($signed($past(mul_a_narrow, 2))
        * $signed($past(mul_b_narrow, 2)))) else $error("narrow product wrong");
    chk_done_drops_req: assert property (!div_req_wide |=> !div_done_wide)
        else $error("done held after request low");
    chk_div_ovf_zeroes: assert property (div_ovf_wide |->
        div_quot_wide == 32'h0000_0000 && div_rem_wide == 32'h0000_0000)
        else $error("overflow results not zero");
    chk_div_zero_ovf: assert property (s_div_zero_start |-> ##[1:40]
        (!div_req_narrow || (div_done_narrow && div_ovf_narrow)))
        else $error("zero divisor not flagged");
    chk_mul_ovf_range: assert property ($rose(mul_done_wide) |-> mul_ovf_wide ==
        (64'($signed($past(mul_a_wide, 2)) * $signed($past(mul_b_wide, 2)))
        != {{32{mul_product_wide[31]}}, mul_product_wide})) else $error("mul overflow wrong");
endmodule : signed_integer_arith_unit
`default_nettype wire

/* File: dv/op_requester.sv */
// behavioural user logic that raises and holds the start requests of the sequential units
`timescale 1ns/1ps
`default_nettype none
module op_requester (
    // clock
    input wire logic clock,
    // handshake with the four sequential units
    input wire logic [3:0] done,
    output logic [3:0] req
);
    // requests idle low so every launch forms a clean rising edge; no enable pin exists,
    // so nothing can gate the units from this side
    initial begin
        req = 4'h0;
    end
    // raise one request, hold it until done (or give up after hold_max cycles), linger only after a done, release
    task automatic run(input int unit, input int hold_max, input int linger, output int lat);
        lat = -1;
        @(negedge clock);
        req[unit] = 1'b1;
        for (int n = 1; n <= hold_max; n++) begin
            @(negedge clock);
            if (done[unit] === 1'b1) begin
                lat = n;
                break;
            end
        end
        // a release before done abandons the operation on purpose
        if (lat > 0) begin
            repeat (linger) @(negedge clock);
        end
        req[unit] = 1'b0;
    endtask : run
endmodule : op_requester
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the signed arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****
    // signals
    // ****
    localparam int MUL_LAT = 2;
    localparam int DIV_LAT = 34;
    localparam logic [31:0] AS_A [6] = '{32'h7fff_ffff, 32'h8000_0000, 32'h8000_0000,
        32'h1234_5678, 32'h0000_7fff, 32'h0000_0000};
    localparam logic [31:0] AS_B [6] = '{32'h0000_0001, 32'hffff_ffff, 32'h0000_0001,
        32'hedcb_a988, 32'h0000_0001, 32'h8000_0000};
    localparam logic [31:0] DV_A [7] = '{32'h0000_0064, 32'hffff_ff9c, 32'h0000_0064,
        32'h0000_0005, 32'h8000_0000, 32'h000f_4240, 32'h0001_86a0};
    localparam logic [31:0] DV_B [7] = '{32'h0000_0007, 32'h0000_0007, 32'hffff_fff9,
        32'h0000_0000, 32'hffff_ffff, 32'h0000_0003, 32'hffff_fffc};
    logic clock = 1'b0;
    logic srst = 1'b1;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] add_a_wide = '0, add_b_wide = '0, sub_a_wide = '0, sub_b_wide = '0;
    logic [15:0] add_a_narrow = '0, add_b_narrow = '0, sub_a_narrow = '0, sub_b_narrow = '0;
    logic [31:0] mul_a_wide = '0, mul_b_wide = '0, div_a_wide = '0, div_b_wide = '0;
    logic [15:0] mul_a_narrow = '0, mul_b_narrow = '0, div_b_narrow = '0;
    logic [31:0] div_a_narrow = '0;
    logic [31:0] add_sum_wide, sub_diff_wide, mul_product_wide, mul_product_narrow;
    logic [31:0] div_quot_wide, div_rem_wide;
    logic [15:0] add_sum_narrow, sub_diff_narrow, div_quot_narrow, div_rem_narrow;
    logic add_ovf_wide, add_ovf_narrow, sub_ovf_wide, sub_ovf_narrow, mul_ovf_wide;
    logic div_ovf_wide, div_ovf_narrow;
    logic mul_done_wide, mul_done_narrow, div_done_wide, div_done_narrow;
    logic [3:0] req_v;
    logic [3:0] done_v;
    // ****
    // design and far side
    // ****
    // unit order follows the package indices
    assign done_v = {div_done_narrow, div_done_wide, mul_done_narrow, mul_done_wide};
    signed_integer_arith_unit dut (.clock, .srst, .add_a_wide, .add_b_wide, .add_sum_wide,
        .add_ovf_wide, .add_a_narrow, .add_b_narrow, .add_sum_narrow, .add_ovf_narrow,
        .sub_a_wide, .sub_b_wide, .sub_diff_wide, .sub_ovf_wide, .sub_a_narrow,
        .sub_b_narrow, .sub_diff_narrow, .sub_ovf_narrow,
        .mul_req_wide(req_v[arith_pkg::U_MUL_W]), .mul_a_wide, .mul_b_wide, .mul_done_wide,
        .mul_product_wide, .mul_ovf_wide, .mul_req_narrow(req_v[arith_pkg::U_MUL_N]),
        .mul_a_narrow, .mul_b_narrow, .mul_done_narrow, .mul_product_narrow,
        .div_req_wide(req_v[arith_pkg::U_DIV_W]), .div_a_wide, .div_b_wide, .div_done_wide,
        .div_quot_wide, .div_rem_wide, .div_ovf_wide,
        .div_req_narrow(req_v[arith_pkg::U_DIV_N]), .div_a_narrow, .div_b_narrow,
        .div_done_narrow, .div_quot_narrow, .div_rem_narrow, .div_ovf_narrow);
    op_requester far (.clock(clock), .done(done_v), .req(req_v));
    // ****
    // clock, timeout and helpers
    // ****
    // 125 MHz
    initial begin
        forever #4 clock = ~clock;
    end
    // ceiling well above the roughly 820 cycles the scenarios need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val
    task automatic check_flag(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_flag
    // signed range test for a w-bit result
    function automatic logic fits(input longint v, input int w);
        longint lim;
        lim = longint'(1) << (w - 1);
        return (v >= -lim) && (v < lim);
    endfunction : fits
    // ****
    // scenarios
    // ****
    task automatic test_reset();
        check_flag(mul_done_wide, 1'b0, "done after reset");
        check_flag(div_done_narrow, 1'b0, "div done after reset");
    endtask : test_reset
    // registered add and subtract, boundary operands around both widths
    task automatic test_addsub();
        longint s, d, sn, dn;
        for (int i = 0; i < 6; i++) begin
            s = longint'($signed(AS_A[i])) + longint'($signed(AS_B[i]));
            d = longint'($signed(AS_A[i])) - longint'($signed(AS_B[i]));
            sn = longint'($signed(AS_A[i][15:0])) + longint'($signed(AS_B[i][15:0]));
            dn = longint'($signed(AS_A[i][15:0])) - longint'($signed(AS_B[i][15:0]));
            add_a_wide = AS_A[i];
            add_b_wide = AS_B[i];
            sub_a_wide = AS_A[i];
            sub_b_wide = AS_B[i];
            add_a_narrow = AS_A[i][15:0];
            add_b_narrow = AS_B[i][15:0];
            sub_a_narrow = AS_A[i][15:0];
            sub_b_narrow = AS_B[i][15:0];
            @(negedge clock);
            check_val(add_sum_wide, s[31:0], "add wide");
            check_val({16'h0, add_sum_narrow}, {16'h0, sn[15:0]}, "add narrow");
            check_flag(add_ovf_wide, !fits(s, 32), "add ovf wide");
            check_flag(add_ovf_narrow, !fits(sn, 16), "add ovf narrow");
            check_val(sub_diff_wide, d[31:0], "sub wide");
            check_val({16'h0, sub_diff_narrow}, {16'h0, dn[15:0]}, "sub narrow");
            check_flag(sub_ovf_wide, !fits(d, 32), "sub ovf wide");
            check_flag(sub_ovf_narrow, !fits(dn, 16), "sub ovf narrow");
        end
    endtask : test_addsub
    // both multipliers on one operand pair; done drops once the request is released
    task automatic mul_case(input logic [31:0] a, input logic [31:0] b);
        longint pw, pn;
        int lat;
        pw = longint'($signed(a)) * longint'($signed(b));
        pn = longint'($signed(a[15:0])) * longint'($signed(b[15:0]));
        mul_a_wide = a;
        mul_b_wide = b;
        mul_a_narrow = a[15:0];
        mul_b_narrow = b[15:0];
        far.run(arith_pkg::U_MUL_W, 60, 0, lat);
        check_val(32'(lat), 32'(MUL_LAT), "mul wide latency");
        check_val(mul_product_wide, pw[31:0], "mul wide");
        check_flag(mul_ovf_wide, !fits(pw, 32), "mul ovf");
        far.run(arith_pkg::U_MUL_N, 60, 0, lat);
        check_val(32'(lat), 32'(MUL_LAT), "mul narrow latency");
        check_val(mul_product_narrow, pn[31:0], "mul narrow");
        @(negedge clock);
        check_flag(mul_done_narrow, 1'b0, "done after release");
    endtask : mul_case
    task automatic test_mul();
        mul_case(32'h0000_0007, 32'hffff_fffd);
        mul_case(32'h0001_8000, 32'h0001_8000);
        mul_case(32'h8000_0000, 32'hffff_ffff);
        mul_case(32'h0000_007b, 32'hffff_ffd3);
    endtask : test_mul
    // a held request must not start a second operation when the operands change
    task automatic test_no_edge();
        int lat;
        mul_a_wide = 32'h0000_0003;
        mul_b_wide = 32'h0000_0004;
        fork
            far.run(arith_pkg::U_MUL_W, 60, 6, lat);
            begin
                repeat (4) @(negedge clock);
                mul_a_wide = 32'h0000_0005;
            end
        join
        check_val(mul_product_wide, 32'h0000_000c, "level restarted");
        @(negedge clock);
    endtask : test_no_edge
    // both dividers on one operand pair, including overflow cases
    task automatic div_case(input logic [31:0] a, input logic [31:0] b);
        longint sa, bw, bn, qw, rw, qn, rn;
        logic ow, on;
        int lat;
        sa = longint'($signed(a));
        bw = longint'($signed(b));
        bn = longint'($signed(b[15:0]));
        qw = (bw == 0) ? 0 : sa / bw;
        rw = (bw == 0) ? 0 : sa % bw;
        qn = (bn == 0) ? 0 : sa / bn;
        rn = (bn == 0) ? 0 : sa % bn;
        ow = (bw == 0) || !fits(qw, 32);
        on = (bn == 0) || !fits(qn, 16);
        div_a_wide = a;
        div_b_wide = b;
        div_a_narrow = a;
        div_b_narrow = b[15:0];
        far.run(arith_pkg::U_DIV_W, 60, 0, lat);
        check_val(32'(lat), 32'(DIV_LAT), "div wide latency");
        check_flag(div_ovf_wide, ow, "div ovf wide");
        check_val(div_quot_wide, ow ? 32'h0 : qw[31:0], "div quot wide");
        check_val(div_rem_wide, ow ? 32'h0 : rw[31:0], "div rem wide");
        far.run(arith_pkg::U_DIV_N, 60, 0, lat);
        check_val(32'(lat), 32'(DIV_LAT), "div narrow latency");
        check_flag(div_ovf_narrow, on, "div ovf narrow");
        check_val({16'h0, div_quot_narrow}, on ? 32'h0 : {16'h0, qn[15:0]}, "quot n");
        check_val({16'h0, div_rem_narrow}, on ? 32'h0 : {16'h0, rn[15:0]}, "rem n");
    endtask : div_case
    task automatic test_div();
        for (int i = 0; i < 7; i++) begin
            div_case(DV_A[i], DV_B[i]);
        end
    endtask : test_div
    // early release on every unit: no done may follow, and a fresh start must still work
    task automatic test_abort();
        int lat;
        int highs;
        div_a_wide = 32'h0000_03e8;
        div_b_wide = 32'h0000_000a;
        for (int u = 0; u < arith_pkg::N_UNITS; u++) begin
            highs = 0;
            far.run(u, (u < 2) ? 1 : 10, 0, lat);
            for (int i = 0; i < 40; i++) begin
                @(negedge clock);
                highs += (done_v[u] !== 1'b0) ? 1 : 0;
            end
            check_val(32'(highs), 32'h0, "done after abort");
        end
        mul_case(32'hffff_fff6, 32'h0000_0009);
        div_case(32'h0000_03e8, 32'h0000_000a);
    endtask : test_abort
    // ****
    // sequence and verdict
    // ****
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // reset held 20 cycles, released off the sampling edge
    initial begin
        repeat (20) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        test_reset();
        test_addsub();
        test_mul();
        test_no_edge();
        test_div();
        test_abort();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
